// ---- hdl/lcd_drv_defines.svh ----
/*
 * Offsets, field positions, reset values and bus codes of the LCD driver.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef LCD_DRV_DEFINES_SVH
`define LCD_DRV_DEFINES_SVH

// ****************************************************************
// Register map
// ****************************************************************
`define LCD_ADDR_W          8
`define LCD_OFF_CONTROL     8'h00
`define LCD_OFF_ROLE_LOW    8'h04
`define LCD_OFF_ROLE_MID    8'h08
`define LCD_OFF_ROLE_HIGH   8'h0C

// ****************************************************************
// Control register fields
// ****************************************************************
`define LCD_BIT_FRAME       7
`define LCD_BIT_BIAS_HI     6
`define LCD_BIT_BIAS_LO     5
`define LCD_BIT_DRIVE_ON    4

// ****************************************************************
// Pin role fields
// ****************************************************************
`define LCD_ROLE_REG_W      8
`define LCD_ROLE_LOW_LSB    0
`define LCD_ROLE_MID_LSB    8
`define LCD_ROLE_HIGH_LSB   16
`define LCD_ROLE_ALL_W      24
`define LCD_PINS_MAX        22

// ****************************************************************
// Reset values and bus answers
// ****************************************************************
`define LCD_RST_CONTROL     8'h00
`define LCD_RST_ROLE        24'h000000
`define AXI_RESP_OKAY       2'h0
`define AXI_RESP_SLVERR     2'h2

`endif

// ---- hdl/lcd_drv_pkg.sv ----
/*
 * Types shared by the LCD driver modules.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package lcd_drv_pkg;

    // ************************************************************
    // Pin drive level and per-pin output bundle
    // ************************************************************
    typedef enum logic [1:0]
    {
        LEVEL_VSS,
        LEVEL_THIRD,
        LEVEL_TWO_THIRDS,
        LEVEL_VDD
    } drive_level_e;

    typedef struct packed
    {
        drive_level_e level;
        logic         common_drive_pin;
        logic         segment_drive_pin;
    } pin_drive_s;

    // ************************************************************
    // Control register content
    // ************************************************************
    typedef enum logic [1:0]
    {
        LADDER_3X200K,
        LADDER_3X100K,
        LADDER_3X33K3,
        LADDER_3X16K6
    } bias_resistor_e;

    typedef struct packed
    {
        logic           frame;
        bias_resistor_e bias_resistor_select;
        logic           lcd_drive_on;
    } drive_control_s;

endpackage

// ---- hdl/lcd_bias_ladder.sv ----
/*
 * Bias resistor ladder select: one-hot string enables for the analog ladder.
 * Assumes aclk domain inputs from the register file.
 */
`timescale 1ns/100ps

module lcd_bias_ladder
(
    // Clock and reset
    input  wire logic                        aclk,
    input  wire logic                        aresetn,
    // Control
    input  wire logic                        lcd_drive_on,
    input  wire lcd_drv_pkg::bias_resistor_e bias_resistor_select,
    // Ladder
    output logic [3:0]                       ladder_tap,
    output logic                             ladder_on
);

    // ************************************************************
    // Registered string enables, all open while off
    // ************************************************************
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ladder_tap <= 4'h0;
            ladder_on  <= 1'h0;
        end
        else
        begin
            ladder_on <= lcd_drive_on;
            for (int i = 0; i < 4; i++)
            begin
                ladder_tap[i] <= lcd_drive_on
                    && (bias_resistor_select == 2'(i));
            end
        end
    end

endmodule

// ---- hdl/lcd_pin_cell.sv ----
/*
 * One shared pin: picks the drive level from frame, role and data bit.
 * Assumes pin data and function select come from logic on aclk.
 */
`timescale 1ns/100ps

module lcd_pin_cell
(
    // Clock and reset
    input  wire logic                    aclk,
    input  wire logic                    aresetn,
    // Control
    input  wire logic                    lcd_drive_on,
    input  wire logic                    frame,
    input  wire logic                    pin_role_select,
    input  wire logic                    pin_lcd_func,
    input  wire logic                    pin_data,
    // Drive
    output lcd_drv_pkg::pin_drive_s      pin_drive
);

    lcd_drv_pkg::pin_drive_s next_pin_drive;

    // ************************************************************
    // Level selection
    // ************************************************************
    always_comb
    begin
        next_pin_drive.level             = lcd_drv_pkg::LEVEL_VSS;
        next_pin_drive.common_drive_pin  = 1'h0;
        next_pin_drive.segment_drive_pin = 1'h0;
        if (lcd_drive_on && pin_lcd_func)
        begin
            next_pin_drive.common_drive_pin  = !pin_role_select;
            next_pin_drive.segment_drive_pin = pin_role_select;
            case ({frame, pin_role_select})
                2'h0: next_pin_drive.level = pin_data
                    ? lcd_drv_pkg::LEVEL_VDD
                    : lcd_drv_pkg::LEVEL_THIRD;
                2'h1: next_pin_drive.level = pin_data
                    ? lcd_drv_pkg::LEVEL_VSS
                    : lcd_drv_pkg::LEVEL_TWO_THIRDS;
                2'h2: next_pin_drive.level = pin_data
                    ? lcd_drv_pkg::LEVEL_VSS
                    : lcd_drv_pkg::LEVEL_TWO_THIRDS;
                default: next_pin_drive.level = pin_data
                    ? lcd_drv_pkg::LEVEL_VDD
                    : lcd_drv_pkg::LEVEL_THIRD;
            endcase
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            pin_drive <= '0;
        end
        else
        begin
            pin_drive <= next_pin_drive;
        end
    end

endmodule

// ---- hdl/lcd_com_seg_driver.sv ----
/*
 * Software driven LCD common/segment driver with an AXI4-Lite register file.
 * Assumes pin data bits and pin function selects come from port logic on
 * aclk; the analog ladder and pad drivers sit outside and follow the
 * registered level codes.
 */
`timescale 1ns/100ps

`include "lcd_drv_defines.svh"

// Contract
// - Master enable gates all common/segment driving
// - Driving ignores the port direction setting
// - Disabled driver holds every output at ground
// - Frame bit selects frame zero or one
// - Frame zero: common full/third, segment ground/two-thirds
// - Frame one: common ground/two-thirds, segment full/third
// - Level set by frame bit, role bit and data bit
// - Two-bit field selects bias ladder strength
// - Role bit zero common, one segment
// - Unimplemented bits read back as zero
module lcd_com_seg_driver
#(
    parameter int PIN_COUNT = 22
)
(
    // Clock and reset
    input  wire logic                       aclk,
    input  wire logic                       aresetn,
    // Write address channel
    input  wire logic [`LCD_ADDR_W-1:0]     awaddr,
    input  wire logic [2:0]                 awprot,
    input  wire logic                       awvalid,
    output logic                            awready,
    // Write data channel
    input  wire logic [31:0]                wdata,
    input  wire logic [3:0]                 wstrb,
    input  wire logic                       wvalid,
    output logic                            wready,
    // Write response channel
    output logic [1:0]                      bresp,
    output logic                            bvalid,
    input  wire logic                       bready,
    // Read address channel
    input  wire logic [`LCD_ADDR_W-1:0]     araddr,
    input  wire logic [2:0]                 arprot,
    input  wire logic                       arvalid,
    output logic                            arready,
    // Read data channel
    output logic [31:0]                     rdata,
    output logic [1:0]                      rresp,
    output logic                            rvalid,
    input  wire logic                       rready,
    // Shared port side
    input  wire logic [PIN_COUNT-1:0]       pin_data,
    input  wire logic [PIN_COUNT-1:0]       pin_lcd_func,
    // Pin drive
    output lcd_drv_pkg::pin_drive_s [PIN_COUNT-1:0] pin_drive,
    // Bias ladder
    output logic [3:0]                      ladder_tap,
    output logic                            ladder_on
);

    // ************************************************************
    // Elaboration check
    // ************************************************************
    generate
        if (PIN_COUNT < 1 || PIN_COUNT > `LCD_PINS_MAX)
        begin : g_bad_count
            $error("PIN_COUNT out of range");
        end
    endgenerate

    localparam logic [`LCD_ROLE_ALL_W-1:0] ROLE_MASK =
        `LCD_ROLE_ALL_W'((25'h1 << PIN_COUNT) - 25'h1);

    // ************************************************************
    // Register state
    // ************************************************************
    lcd_drv_pkg::drive_control_s        drive_control;
    logic [`LCD_ROLE_ALL_W-1:0]         pin_role_select;

    // ************************************************************
    // Write channel state
    // ************************************************************
    logic                               aw_full;
    logic                               w_full;
    logic [`LCD_ADDR_W-1:0]             aw_addr_held;
    logic [7:0]                         w_byte_held;
    logic                               w_lane_held;
    logic                               write_fire;
    logic                               write_hit;
    logic                               write_lane;
    logic [`LCD_ADDR_W-1:0]             write_word;

    // ************************************************************
    // Read channel state
    // ************************************************************
    logic [`LCD_ADDR_W-1:0]             read_word;
    logic [7:0]                         next_read_byte;
    logic                               next_read_hit;

    // ************************************************************
    // Handshake outputs
    // ************************************************************
    assign awready = !aw_full;
    assign wready  = !w_full;
    assign arready = !rvalid;

    // Both halves held and no response pending
    assign write_fire = aw_full && w_full && !bvalid;
    assign write_lane = w_lane_held;
    assign write_word = {aw_addr_held[`LCD_ADDR_W-1:2], 2'h0};
    assign write_hit  = (write_word == `LCD_OFF_CONTROL)
                     || (write_word == `LCD_OFF_ROLE_LOW)
                     || (write_word == `LCD_OFF_ROLE_MID)
                     || (write_word == `LCD_OFF_ROLE_HIGH);

    // ************************************************************
    // Write address capture
    // ************************************************************
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_full      <= 1'h0;
            aw_addr_held <= '0;
        end
        else if (awvalid && awready)
        begin
            aw_full      <= 1'h1;
            aw_addr_held <= awaddr;
        end
        else if (write_fire)
        begin
            aw_full <= 1'h0;
        end
    end

    // ************************************************************
    // Write data capture
    // ************************************************************
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            w_full      <= 1'h0;
            w_byte_held <= 8'h00;
            w_lane_held <= 1'h0;
        end
        else if (wvalid && wready)
        begin
            w_full      <= 1'h1;
            w_byte_held <= wdata[7:0];
            w_lane_held <= wstrb[0];
        end
        else if (write_fire)
        begin
            w_full <= 1'h0;
        end
    end

    // ************************************************************
    // Write response
    // ************************************************************
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            bvalid <= 1'h0;
            bresp  <= `AXI_RESP_OKAY;
        end
        else if (write_fire)
        begin
            bvalid <= 1'h1;
            bresp  <= write_hit ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
        end
        else if (bready)
        begin
            bvalid <= 1'h0;
        end
    end

    // ************************************************************
    // Control register
    // ************************************************************
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            drive_control <= 4'(`LCD_RST_CONTROL >> `LCD_BIT_DRIVE_ON);
        end
        else if (write_fire && write_lane
                 && write_word == `LCD_OFF_CONTROL)
        begin
            drive_control.frame <= w_byte_held[`LCD_BIT_FRAME];
            drive_control.bias_resistor_select <=
                lcd_drv_pkg::bias_resistor_e'(
                    w_byte_held[`LCD_BIT_BIAS_HI:`LCD_BIT_BIAS_LO]);
            drive_control.lcd_drive_on <=
                w_byte_held[`LCD_BIT_DRIVE_ON];
        end
    end

    // ************************************************************
    // Pin role registers
    // ************************************************************
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            pin_role_select <= `LCD_RST_ROLE;
        end
        else if (write_fire && write_lane)
        begin
            case (write_word)
                `LCD_OFF_ROLE_LOW:
                begin
                    pin_role_select[`LCD_ROLE_LOW_LSB +: `LCD_ROLE_REG_W]
                        <= w_byte_held
                        & ROLE_MASK[`LCD_ROLE_LOW_LSB +: `LCD_ROLE_REG_W];
                end
                `LCD_OFF_ROLE_MID:
                begin
                    pin_role_select[`LCD_ROLE_MID_LSB +: `LCD_ROLE_REG_W]
                        <= w_byte_held
                        & ROLE_MASK[`LCD_ROLE_MID_LSB +: `LCD_ROLE_REG_W];
                end
                `LCD_OFF_ROLE_HIGH:
                begin
                    pin_role_select[`LCD_ROLE_HIGH_LSB +: `LCD_ROLE_REG_W]
                        <= w_byte_held
                        & ROLE_MASK[`LCD_ROLE_HIGH_LSB +: `LCD_ROLE_REG_W];
                end
                default:
                begin
                    pin_role_select <= pin_role_select;
                end
            endcase
        end
    end

    // ************************************************************
    // Read decode
    // ************************************************************
    assign read_word = {araddr[`LCD_ADDR_W-1:2], 2'h0};

    always_comb
    begin
        next_read_byte = 8'h00;
        next_read_hit  = 1'h1;
        case (read_word)
            `LCD_OFF_CONTROL:
            begin
                next_read_byte = {drive_control, 4'h0};
            end
            `LCD_OFF_ROLE_LOW:
            begin
                next_read_byte =
                    pin_role_select[`LCD_ROLE_LOW_LSB +: `LCD_ROLE_REG_W];
            end
            `LCD_OFF_ROLE_MID:
            begin
                next_read_byte =
                    pin_role_select[`LCD_ROLE_MID_LSB +: `LCD_ROLE_REG_W];
            end
            `LCD_OFF_ROLE_HIGH:
            begin
                next_read_byte =
                    pin_role_select[`LCD_ROLE_HIGH_LSB +: `LCD_ROLE_REG_W];
            end
            default:
            begin
                next_read_hit = 1'h0;
            end
        endcase
    end

    // ************************************************************
    // Read response
    // ************************************************************
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rvalid <= 1'h0;
            rdata  <= 32'h00000000;
            rresp  <= `AXI_RESP_OKAY;
        end
        else if (arvalid && arready)
        begin
            rvalid <= 1'h1;
            rdata  <= {24'h000000, next_read_byte};
            rresp  <= next_read_hit ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
        end
        else if (rready)
        begin
            rvalid <= 1'h0;
        end
    end

    // ************************************************************
    // Pin cells
    // ************************************************************
    generate
        for (genvar p = 0; p < PIN_COUNT; p++)
        begin : g_pin
            lcd_pin_cell u_cell
            (
                .aclk            (aclk),
                .aresetn         (aresetn),
                .lcd_drive_on    (drive_control.lcd_drive_on),
                .frame           (drive_control.frame),
                .pin_role_select (pin_role_select[p]),
                .pin_lcd_func    (pin_lcd_func[p]),
                .pin_data        (pin_data[p]),
                .pin_drive       (pin_drive[p])
            );
        end
    endgenerate

    // ************************************************************
    // Bias ladder
    // ************************************************************
    lcd_bias_ladder u_ladder
    (
        .aclk                 (aclk),
        .aresetn              (aresetn),
        .lcd_drive_on         (drive_control.lcd_drive_on),
        .bias_resistor_select (drive_control.bias_resistor_select),
        .ladder_tap           (ladder_tap),
        .ladder_on            (ladder_on)
    );

endmodule

// ---- test/lcd_drv_asserts.sv ----
/*
 * Port checker for the LCD driver: bus answers, pin levels, ladder select.
 * Assumes binding into lcd_com_seg_driver with pins 0 and 1 present.
 */
`timescale 1ns/100ps

module lcd_drv_asserts
#(
    parameter int PIN_COUNT = 22
)
(
    // Clock and reset
    input wire logic                                   aclk,
    input wire logic                                   aresetn,
    // Bus
    input wire logic                                   bvalid,
    input wire logic                                   bready,
    input wire logic [1:0]                             bresp,
    input wire logic                                   arvalid,
    input wire logic                                   arready,
    input wire logic                                   rvalid,
    input wire logic                                   rready,
    input wire logic [31:0]                            rdata,
    // Pins
    input wire logic [PIN_COUNT-1:0]                   pin_data,
    input wire logic [PIN_COUNT-1:0]                   pin_lcd_func,
    input wire lcd_drv_pkg::pin_drive_s [PIN_COUNT-1:0] pin_drive,
    input wire logic [3:0]                             ladder_tap,
    input wire logic                                   ladder_on
);
    logic [1:0] lv0;
    logic [1:0] lv1;
    logic       act0;

    assign lv0  = pin_drive[0].level;
    assign lv1  = pin_drive[1].level;
    assign act0 = |pin_drive[0][1:0];

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    // ****************************************************************
    // Properties
    // ****************************************************************
    property p_idle_pin;
        !$past(pin_lcd_func[0]) |-> pin_drive[0] == '0;
    endproperty
    property p_rail_data;
        act0 |-> (lv0[1] == lv0[0]) == $past(pin_data[0]);
    endproperty
    property p_frame_phase;
        pin_drive[0].common_drive_pin && pin_drive[1].segment_drive_pin
            |-> lv0[0] != lv1[0];
    endproperty
    property p_role_excl;
        !(pin_drive[0].common_drive_pin && pin_drive[0].segment_drive_pin);
    endproperty
    property p_ladder_hot;
        ladder_on ? $onehot(ladder_tap) : ladder_tap == 4'h0;
    endproperty
    property p_resp_hold;
        bvalid && !bready |=> bvalid && $stable(bresp);
    endproperty
    property p_read_answer;
        arvalid && arready |=> rvalid && rdata[31:8] == 24'h000000;
    endproperty
    property p_read_hold;
        rvalid && !rready |=> rvalid && $stable(rdata);
    endproperty
    property p_off_ground;
        !ladder_on |-> pin_drive == '0;
    endproperty

    a_idle_pin:    assert property (p_idle_pin)    else $error("idle pin");
    a_off_ground:  assert property (p_off_ground)  else $error("off");
    a_rail_data:   assert property (p_rail_data)   else $error("rail");
    a_frame_phase: assert property (p_frame_phase) else $error("phase");
    a_role_excl:   assert property (p_role_excl)   else $error("role");
    a_ladder_hot:  assert property (p_ladder_hot)  else $error("ladder");
    a_resp_hold:   assert property (p_resp_hold)   else $error("bresp");
    a_read_answer: assert property (p_read_answer) else $error("rdata");
    a_read_hold:   assert property (p_read_hold)   else $error("rhold");

    c_common: cover property (pin_drive[0].common_drive_pin);
    c_segment: cover property (pin_drive[1].segment_drive_pin);
    c_read: cover property (rvalid && rready);
endmodule

bind lcd_com_seg_driver lcd_drv_asserts #(.PIN_COUNT(PIN_COUNT)) u_asserts
(
    .aclk, .aresetn, .bvalid, .bready, .bresp, .arvalid, .arready, .rvalid,
    .rready, .rdata, .pin_data, .pin_lcd_func, .pin_drive, .ladder_tap,
    .ladder_on
);

// ---- test/lcd_panel_model.sv ----
/*
 * LCD panel electrodes: notes which pins have acted as common or segment.
 * Assumes pin_drive from the driver on aclk.
 */
`timescale 1ns/100ps

module lcd_panel_model
#(
    parameter int PIN_COUNT = 22
)
(
    // Clock
    input wire logic                                   aclk,
    // Electrodes
    input wire lcd_drv_pkg::pin_drive_s [PIN_COUNT-1:0] pin_drive,
    // Seen roles
    output logic [PIN_COUNT-1:0]                       com_seen,
    output logic [PIN_COUNT-1:0]                       seg_seen
);
    initial com_seen = '0;
    initial seg_seen = '0;

    always @(posedge aclk)
    begin
        for (int k = 0; k < PIN_COUNT; k++)
        begin
            com_seen[k] <= com_seen[k] || pin_drive[k].common_drive_pin === 1;
            seg_seen[k] <= seg_seen[k] || pin_drive[k].segment_drive_pin === 1;
        end
    end
endmodule

// ---- test/testbench.sv ----
/*
 * Self-checking bench: AXI4-Lite register access, pin levels, ladder.
 * Assumes the design package, defines header and panel model are compiled.
 */
`timescale 1ns/100ps

`include "lcd_drv_defines.svh"

module testbench;
    localparam int PINS = 22;
    logic                             aclk, aresetn;
    logic [7:0]                       awaddr, araddr, ctrl;
    logic [31:0]                      wdata, rdata, r;
    logic [3:0]                       wstrb, ladder_tap;
    logic                             awvalid, awready, wvalid, wready;
    logic                             bvalid, bready, arvalid, arready;
    logic                             rvalid, rready, ladder_on;
    logic [1:0]                       bresp, rresp;
    logic [PINS-1:0]                  pin_data, pin_lcd_func;
    logic [PINS-1:0]                  com_seen, seg_seen;
    lcd_drv_pkg::pin_drive_s [PINS-1:0] pin_drive;
    logic [23:0]                      role;
    int                               n_mismatch, n_tests, seed, i, j;
    int                               cycles = 0;

    lcd_com_seg_driver #(.PIN_COUNT(PINS)) dut
    (
        .aclk, .aresetn, .awaddr, .awprot(3'h0), .awvalid, .awready, .wdata,
        .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
        .arprot(3'h0), .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
        .pin_data, .pin_lcd_func, .pin_drive, .ladder_tap, .ladder_on
    );

    lcd_panel_model #(.PIN_COUNT(PINS)) u_panel
    (
        .aclk, .pin_drive, .com_seen, .seg_seen
    );

    // ****************************************************************
    // Tasks
    // ****************************************************************
    task automatic wrap_up();
        $display("tests %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask

    function automatic logic [1:0] exp_resp(input logic [7:0] a);
        return (a[7:2] < 6'd4) ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
    endfunction

    function automatic logic [31:0] exp_reg(input logic [7:0] a);
        case (a[7:2])
            6'd0: return {24'h000000, ctrl};
            6'd1: return {24'h000000, role[7:0]};
            6'd2: return {24'h000000, role[15:8]};
            6'd3: return {24'h000000, role[23:16]};
            default: return 32'h00000000;
        endcase
    endfunction

    function automatic lcd_drv_pkg::pin_drive_s exp_pin(input int k);
        lcd_drv_pkg::pin_drive_s p;
        logic                    x;
        p = '0;
        x = ctrl[7] ^ role[k];
        if (ctrl[4] && pin_lcd_func[k])
        begin
            p.common_drive_pin  = !role[k];
            p.segment_drive_pin = role[k];
            if (pin_data[k])
                p.level = x ? lcd_drv_pkg::LEVEL_VSS : lcd_drv_pkg::LEVEL_VDD;
            else
                p.level = x ? lcd_drv_pkg::LEVEL_TWO_THIRDS
                            : lcd_drv_pkg::LEVEL_THIRD;
        end
        return p;
    endfunction

    task automatic axi_write(input logic [7:0] a, input logic [7:0] d,
                             input logic [3:0] s);
        if (s[0] && a[7:2] == 6'd0)
            ctrl = d & 8'hF0;
        else if (s[0] && a[7:2] < 6'd4)
            role[8*(a[3:2]-1) +: 8] = d & ((a[3:2] == 2'd3) ? 8'h3F : 8'hFF);
        awaddr  <= a;
        wdata   <= {24'h000000, d};
        wstrb   <= s;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (awvalid && awready)
                awvalid <= 1'b0;
            if (wvalid && wready)
                wvalid <= 1'b0;
        end
        while (awvalid || wvalid);
        do
            @(posedge aclk);
        while (!bvalid);
        check(32'(bresp), 32'(exp_resp(a)));
        bready <= 1'b0;
        @(posedge aclk);
    endtask

    task automatic axi_read(input logic [7:0] a);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do
            @(posedge aclk);
        while (!arready);
        arvalid <= 1'b0;
        do
            @(posedge aclk);
        while (!rvalid);
        check(rdata, exp_reg(a));
        check(32'(rresp), 32'(exp_resp(a)));
        rready <= 1'b0;
        @(posedge aclk);
    endtask

    // ****************************************************************
    // Clock, timeout and sequence
    // ****************************************************************
    initial
    begin
        aclk = 1'b0;
        forever #12.5 aclk = ~aclk;
    end

    always @(posedge aclk)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            n_mismatch++;
            wrap_up();
        end
    end

    initial
    begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
        {awaddr, araddr, wdata, wstrb, pin_data, pin_lcd_func} = '0;
        {ctrl, role, n_mismatch, n_tests} = '0;
        seed = 42243;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        for (i = 0; i < 5; i++)
            axi_read(8'(4 * i));
        axi_write(8'h10, 8'hFF, 4'hF);
        axi_write(8'h00, 8'hF0, 4'hE);
        axi_read(8'h00);
        for (i = 0; i < 40; i++)
        begin
            r = $random(seed);
            axi_write(8'h04, r[15:8], 4'hF);
            axi_write(8'h08, r[23:16], 4'hF);
            axi_write(8'h0E, r[31:24], 4'hF);
            axi_write(8'h00, {r[7], i[1:0], i[2] | i[3], r[3:0]}, 4'hF);
            pin_data     <= PINS'($random(seed));
            pin_lcd_func <= PINS'($random(seed));
            repeat (2) @(posedge aclk);
            for (j = 0; j < PINS; j++)
                check(32'(pin_drive[j]), 32'(exp_pin(j)));
            check({ladder_on, ladder_tap},
                  {ctrl[4], ctrl[4] ? 4'h1 << ctrl[6:5] : 4'h0});
            for (j = 0; j < 4; j++)
                axi_read(8'(4 * j));
        end
        check(32'(|com_seen && |seg_seen), 32'h1);
        wrap_up();
    end
endmodule
